// *** core/pin_mux_consts.svh ***
// Constants for the general-purpose pin multiplexer
`ifndef PIN_MUX_CONSTS_SVH
`define PIN_MUX_CONSTS_SVH

// ----------------------------------------------------------------------
// Pin count and alternate-function pin positions
// ----------------------------------------------------------------------
`define PM_NUM_PINS 12
`define PM_PIN_THERM_PWR 11
`define PM_PIN_RC_DRIVE 10
`define PM_PIN_PARK 8
`define PM_PIN_GLASSES 4
`define PM_PIN_SEL_ZERO 3
`define PM_PIN_SER_OUT 2
`define PM_PIN_SER_CLK 1
`define PM_PIN_SER_IN 0

// ----------------------------------------------------------------------
// Per-pin alternate selection codes (2 bits)
// ----------------------------------------------------------------------
`define PM_ALT_NONE 2'h0
`define PM_ALT_FIRST 2'h1
`define PM_ALT_SECOND 2'h2

// ----------------------------------------------------------------------
// Reset values and strap decoding
// ----------------------------------------------------------------------
`define PM_LANE_CODE_RST 2'h0
`define PM_LANE_COUNT_RST 3'h1
`define PM_BIT_LOW 1'h0
`define PM_BIT_HIGH 1'h1

`endif

// *** core/pin_mux_pkg.sv ***
// Types shared by the general-purpose pin multiplexer
package pin_mux_pkg;

  // Electrical role of a plain general-purpose pin
  typedef enum logic [1:0] {
    pin_input,
    pin_output,
    pin_bidir,
    pin_open_drain
  } pin_mode_type;

  // Boot sequence of the lane-count strap capture
  typedef enum logic [1:0] {
    boot_hold,
    boot_sample,
    boot_run
  } boot_state_type;

endpackage

// *** core/pin_cell.sv ***
// One general-purpose pin: plain role or alternate drive
`timescale 1ns/1ps
`include "pin_mux_consts.svh"
module pin_cell (
  input wire logic [1:0] mode,
  input wire logic sw_out,
  input wire logic sw_dir,
  input wire logic alt_active,
  input wire logic alt_drives,
  input wire logic alt_value,
  output logic pad_out,
  output logic pad_oe
);

  always_comb begin
    pad_out = `PM_BIT_LOW;
    pad_oe = `PM_BIT_LOW;
    if (alt_active) begin
      pad_out = alt_value;
      pad_oe = alt_drives;
    end else begin
      unique case (pin_mux_pkg::pin_mode_type'(mode))
        pin_mux_pkg::pin_input: begin
          pad_oe = `PM_BIT_LOW;
        end
        pin_mux_pkg::pin_output: begin
          pad_out = sw_out;
          pad_oe = `PM_BIT_HIGH;
        end
        pin_mux_pkg::pin_bidir: begin
          pad_out = sw_out;
          pad_oe = sw_dir;
        end
        pin_mux_pkg::pin_open_drain: begin
          // Only ever pulls low; a board pull-up makes the high level
          pad_out = `PM_BIT_LOW;
          pad_oe = ~sw_out;
        end
      endcase
    end
  end

endmodule // pin_cell

// *** core/gpio_altfunc_pin_mux.sv ***
// General-purpose pin multiplexer with alternate functions and boot straps
`timescale 1ns/1ps
`include "pin_mux_consts.svh"

// Overview of operation
// - Each pin: input, output, bidir or open-drain.
// - Software picks plain or alternate role per pin.
// - Pin 11 alternate: thermistor power enable output.
// - Pin 10 alternate: thermistor Thermistor_rc_drive drive.
// - Pin 8 low parks mirror array, power untouched.
// - Pin 4 glasses output: 1 left, 0 right.
// - Pin 4 alternately aux select one, active low.
// - Pin 3 drives aux select zero, active low.
// - Pins 2,1,0: aux data out, clock, in.
// - Pins 2 and 1 sampled at boot.
// - Strap code 00..11 gives 1..4 lanes.
// - After sampling, pins 2,1 serve aux serial again.
module gpio_altfunc_pin_mux #(
  parameter int NUM_PINS = `PM_NUM_PINS
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // Software configuration
  input wire logic cfg_load,
  input wire logic [2*NUM_PINS-1:0] cfg_mode,
  input wire logic [2*NUM_PINS-1:0] cfg_alt,
  input wire logic [NUM_PINS-1:0] sw_out,
  input wire logic [NUM_PINS-1:0] sw_dir,
  output logic [NUM_PINS-1:0] sw_in_r,
  // Alternate function sources inside the device
  input wire logic thermistor_used,
  input wire logic thermistor_enable,
  input wire logic thermistor_rc_drive,
  input wire logic glasses_left,
  input wire logic aux_select_one_n,
  input wire logic aux_select_zero_n,
  input wire logic aux_serial_out,
  input wire logic aux_serial_clk,
  output logic aux_serial_in_r,
  output logic park_request_r,
  // Lane-count strap result
  output logic [1:0] lane_code_r,
  output logic [2:0] lane_count_r,
  output logic strap_valid_r,
  // Pads
  input wire logic [NUM_PINS-1:0] pad_in,
  output logic [NUM_PINS-1:0] pad_out_r,
  output logic [NUM_PINS-1:0] pad_oe_r
);

  // --------------------------------------------------------------------
  // Functions
  // --------------------------------------------------------------------
  // Which alternate code is legal on a pin; anything else is plain I/O
  function automatic logic alt_legal(input int pin, input logic [1:0] code);
    logic ok;
    ok = `PM_BIT_LOW;
    if (code == `PM_ALT_FIRST) begin
      ok = (pin == `PM_PIN_THERM_PWR) || (pin == `PM_PIN_RC_DRIVE) ||
           (pin == `PM_PIN_PARK) || (pin == `PM_PIN_GLASSES) ||
           (pin == `PM_PIN_SEL_ZERO) || (pin == `PM_PIN_SER_OUT) ||
           (pin == `PM_PIN_SER_CLK) || (pin == `PM_PIN_SER_IN);
    end else if (code == `PM_ALT_SECOND) begin
      ok = (pin == `PM_PIN_GLASSES);
    end
    return ok;
  endfunction

  function automatic logic [2:0] lanes_from_code(input logic [1:0] code);
    return {1'h0, code} + `PM_LANE_COUNT_RST;
  endfunction

  // Pin n owns bits [2n+1:2n] of a packed alternate-code vector
  function automatic logic [1:0] alt_code(input logic [2*NUM_PINS-1:0] codes,
                                          input int pin);
    return codes[2*pin +: 2];
  endfunction

  // Pins that carry a lane-count strap during boot
  function automatic logic is_strap_pin(input int pin);
    return (pin == `PM_PIN_SER_OUT) || (pin == `PM_PIN_SER_CLK);
  endfunction

  // --------------------------------------------------------------------
  // Configuration registers
  // --------------------------------------------------------------------
  logic [2*NUM_PINS-1:0] mode_r;
  logic [2*NUM_PINS-1:0] mode_nxt;
  logic [2*NUM_PINS-1:0] alt_r;
  logic [2*NUM_PINS-1:0] alt_nxt;
  logic [NUM_PINS-1:0] alt_on;

  always_comb begin
    mode_nxt = mode_r;
    alt_nxt = alt_r;
    if (cfg_load) begin
      mode_nxt = cfg_mode;
      alt_nxt = cfg_alt;
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      mode_r <= '0;
      alt_r <= '0;
    end else begin
      mode_r <= mode_nxt;
      alt_r <= alt_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Boot strap capture
  // --------------------------------------------------------------------
  pin_mux_pkg::boot_state_type boot_r;
  pin_mux_pkg::boot_state_type boot_nxt;
  logic [1:0] lane_code_nxt;
  logic [2:0] lane_count_nxt;
  logic strap_valid_nxt;

  always_comb begin
    boot_nxt = boot_r;
    lane_code_nxt = lane_code_r;
    lane_count_nxt = lane_count_r;
    strap_valid_nxt = strap_valid_r;
    unique case (boot_r)
      pin_mux_pkg::boot_hold: begin
        // First edge after release: pads still undriven, straps settled
        boot_nxt = pin_mux_pkg::boot_sample;
      end
      pin_mux_pkg::boot_sample: begin
        lane_code_nxt = {pad_in[`PM_PIN_SER_OUT],
                         pad_in[`PM_PIN_SER_CLK]};
        lane_count_nxt = lanes_from_code(lane_code_nxt);
        strap_valid_nxt = `PM_BIT_HIGH;
        boot_nxt = pin_mux_pkg::boot_run;
      end
      pin_mux_pkg::boot_run: begin
        boot_nxt = pin_mux_pkg::boot_run;
      end
      default: begin
        // Unused code: never resample, the straps are taken only once
        boot_nxt = pin_mux_pkg::boot_run;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      boot_r <= pin_mux_pkg::boot_hold;
      lane_code_r <= `PM_LANE_CODE_RST;
      lane_count_r <= `PM_LANE_COUNT_RST;
      strap_valid_r <= `PM_BIT_LOW;
    end else begin
      boot_r <= boot_nxt;
      lane_code_r <= lane_code_nxt;
      lane_count_r <= lane_count_nxt;
      strap_valid_r <= strap_valid_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Alternate function routing
  // --------------------------------------------------------------------
  logic [NUM_PINS-1:0] alt_drv;
  logic [NUM_PINS-1:0] alt_val;
  logic [NUM_PINS-1:0] cell_out;
  logic [NUM_PINS-1:0] cell_oe;
  logic strap_window;

  // Strap pins stay released until the sample is taken
  assign strap_window = (boot_r != pin_mux_pkg::boot_run);

  always_comb begin
    alt_drv = '0;
    alt_val = '0;
    alt_drv[`PM_PIN_THERM_PWR] = `PM_BIT_HIGH;
    alt_val[`PM_PIN_THERM_PWR] = thermistor_used & thermistor_enable;
    alt_drv[`PM_PIN_RC_DRIVE] = `PM_BIT_HIGH;
    alt_val[`PM_PIN_RC_DRIVE] = thermistor_rc_drive;
    // Park request and serial data in are inputs: no drive
    alt_drv[`PM_PIN_GLASSES] = `PM_BIT_HIGH;
    if (alt_code(alt_r, `PM_PIN_GLASSES) == `PM_ALT_SECOND) begin
      alt_val[`PM_PIN_GLASSES] = aux_select_one_n;
    end else begin
      alt_val[`PM_PIN_GLASSES] = glasses_left;
    end
    alt_drv[`PM_PIN_SEL_ZERO] = `PM_BIT_HIGH;
    alt_val[`PM_PIN_SEL_ZERO] = aux_select_zero_n;
    alt_drv[`PM_PIN_SER_OUT] = `PM_BIT_HIGH;
    alt_val[`PM_PIN_SER_OUT] = aux_serial_out;
    alt_drv[`PM_PIN_SER_CLK] = `PM_BIT_HIGH;
    alt_val[`PM_PIN_SER_CLK] = aux_serial_clk;
  end

  // --------------------------------------------------------------------
  // Per-pin cells
  // --------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_pin
      assign alt_on[gi] = alt_legal(gi, alt_code(alt_r, gi));
      pin_cell u_cell (
        .mode(mode_r[2*gi +: 2]),
        .sw_out(sw_out[gi]),
        .sw_dir(sw_dir[gi]),
        .alt_active(alt_on[gi]),
        .alt_drives(alt_drv[gi]),
        .alt_value(alt_val[gi]),
        .pad_out(cell_out[gi]),
        .pad_oe(cell_oe[gi])
      );
    end
  endgenerate

  // --------------------------------------------------------------------
  // Strap pin hand-back
  // --------------------------------------------------------------------
  logic [NUM_PINS-1:0] strap_mask;

  generate
    for (gi = 0; gi < NUM_PINS; gi++) begin : g_strap
      assign strap_mask[gi] = strap_window & is_strap_pin(gi);
    end
  endgenerate

  // --------------------------------------------------------------------
  // Pad drive registers
  // --------------------------------------------------------------------
  logic [NUM_PINS-1:0] pad_out_nxt;
  logic [NUM_PINS-1:0] pad_oe_nxt;

  always_comb begin
    pad_out_nxt = cell_out;
    // Serial pins resume their configured outputs once the straps are held
    pad_oe_nxt = cell_oe & ~strap_mask;
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      pad_out_r <= '0;
      pad_oe_r <= '0;
    end else begin
      pad_out_r <= pad_out_nxt;
      pad_oe_r <= pad_oe_nxt;
    end
  end

  // --------------------------------------------------------------------
  // Input sample registers
  // --------------------------------------------------------------------
  logic [NUM_PINS-1:0] sw_in_nxt;
  logic park_nxt;
  logic ser_in_nxt;

  always_comb begin
    // Every pad is sampled whatever its role, so driven pins read back
    sw_in_nxt = pad_in;
    // Array stays powered; the companion chip owns power-down
    park_nxt = alt_on[`PM_PIN_PARK] &
               (pad_in[`PM_PIN_PARK] == `PM_BIT_LOW);
    ser_in_nxt = alt_on[`PM_PIN_SER_IN] & pad_in[`PM_PIN_SER_IN];
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      sw_in_r <= '0;
      park_request_r <= `PM_BIT_LOW;
      aux_serial_in_r <= `PM_BIT_LOW;
    end else begin
      sw_in_r <= sw_in_nxt;
      park_request_r <= park_nxt;
      aux_serial_in_r <= ser_in_nxt;
    end
  end

endmodule // gpio_altfunc_pin_mux

// *** dv/gpio_altfunc_pin_mux_props.sv ***
// Port assertions for the pin multiplexer
`timescale 1ns/1ps
module gpio_altfunc_pin_mux_props #(
  parameter int NUM_PINS = 12
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic cfg_load,
  input wire logic [2*NUM_PINS-1:0] cfg_alt,
  input wire logic [NUM_PINS-1:0] pad_in,
  input wire logic [NUM_PINS-1:0] sw_in_r,
  input wire logic [NUM_PINS-1:0] pad_out_r,
  input wire logic [NUM_PINS-1:0] pad_oe_r,
  input wire logic thermistor_used,
  input wire logic thermistor_enable,
  input wire logic glasses_left,
  input wire logic aux_serial_in_r,
  input wire logic park_request_r,
  input wire logic [1:0] lane_code_r,
  input wire logic [2:0] lane_count_r,
  input wire logic strap_valid_r
);
  default clocking @(posedge mclk); endclocking
  default disable iff (sys_rst);
  // Mirror of loaded codes; pads may lag it by one edge
  logic [2*NUM_PINS-1:0] alt_r;
  logic [2*NUM_PINS-1:0] alt_nxt;
  always_comb begin
    alt_nxt = alt_r;
    if (sys_rst) begin
      alt_nxt = '0;
    end else if (cfg_load) begin
      alt_nxt = cfg_alt;
    end
  end
  always_ff @(posedge mclk) begin
    alt_r <= alt_nxt;
  end
  sequence settled;
    (!cfg_load) [*3];
  endsequence
  reset_default_a: assert property (
    $fell(sys_rst) |-> pad_oe_r == '0 && lane_count_r == 3'h1
  ) else $error("outputs not at reset values");
  strap_time_a: assert property (
    $fell(sys_rst) |=> !strap_valid_r ##1
      (strap_valid_r && lane_code_r == $past(pad_in[2:1]))
  ) else $error("strap not latched on second edge");
  strap_hold_a: assert property (
    $past(strap_valid_r) && strap_valid_r |-> $stable(lane_code_r)
  ) else $error("lane code changed after latch");
  lane_map_a: assert property (
    strap_valid_r |-> lane_count_r == {1'h0, lane_code_r} + 3'h1
  ) else $error("lane count does not match code");
  strap_oe_a: assert property (
    !strap_valid_r |-> pad_oe_r[2:1] == 2'h0
  ) else $error("strap pins driven before latch");
  park_req_a: assert property (
    park_request_r |-> !$past(pad_in[8])
  ) else $error("park request without low pin");
  serial_in_a: assert property (
    aux_serial_in_r |-> $past(pad_in[0])
  ) else $error("serial input does not follow pin");
  sample_in_a: assert property (
    !$past(sys_rst) |-> sw_in_r == $past(pad_in)
  ) else $error("input sample wrong");
  therm_pwr_a: assert property (
    settled ##0 alt_r[23:22] == 2'h1 |-> pad_oe_r[11] &&
      pad_out_r[11] == $past(thermistor_used & thermistor_enable)
  ) else $error("thermistor power pin wrong");
  glasses_a: assert property (
    settled ##0 alt_r[9:8] == 2'h1 |->
      pad_oe_r[4] && pad_out_r[4] == $past(glasses_left)
  ) else $error("glasses pin wrong");
endmodule // gpio_altfunc_pin_mux_props

// *** dv/pad_far_side.sv ***
// Far-side pad model: host, companion chip and board pulls
`timescale 1ns/1ps
module pad_far_side (
  input wire logic [11:0] pad_out,
  input wire logic [11:0] pad_oe,
  input wire logic host_projector_on,
  input wire logic companion_data,
  input wire logic [1:0] strap_code,
  output logic [11:0] pad_in
);
  logic [11:0] idle;
  always_comb begin
    idle = 12'h018;
    idle[8] = host_projector_on;
    idle[0] = companion_data;
    idle[2:1] = strap_code;
    pad_in = (pad_out & pad_oe) | (idle & ~pad_oe);
  end
endmodule // pad_far_side

// *** dv/gpio_altfunc_pin_mux_tb_top.sv ***
// Self-checking bench for the pin multiplexer
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
  begin \
    compares++; \
    if ((got) !== (exp)) begin \
      $display("wrong value %s exp %0h got %0h", nm, exp, got); \
      errors++; \
    end \
  end
module gpio_altfunc_pin_mux_tb_top;
  typedef struct {
    logic [23:0] mode, alt;
    logic [11:0] out, dir;
    logic [7:0] src;
    logic [11:0] exp_out, exp_oe;
  } row_type;
  row_type rows [8] = '{
    '{24'h555555, 24'h0, 12'hA5A, 12'h0, 8'h0, 12'hA5A, 12'hFFF},
    '{24'h0, 24'h0, 12'hFFF, 12'h0, 8'h0, 12'h000, 12'h000},
    '{24'hFFFFFF, 24'h0, 12'h0F0, 12'h0, 8'h0, 12'h000, 12'hF0F},
    '{24'hAAAAAA, 24'h0, 12'h005, 12'h00F, 8'h0, 12'h005, 12'h00F},
    '{24'h0, 24'h510155, 12'h0, 12'h0, 8'hDA, 12'h814, 12'hC1E},
    '{24'h0, 24'h400200, 12'h0, 12'h0, 8'h94, 12'h000, 12'h810},
    '{24'h0, 24'h000200, 12'h0, 12'h0, 8'h08, 12'h010, 12'h010},
    '{24'h0, 24'h510955, 12'h0, 12'h0, 8'h65, 12'h40A, 12'hC1E}};
  int errors, compares;
  logic mclk, sys_rst, cfg_load, host_projector_on, companion_data;
  logic [23:0] cfg_mode, cfg_alt;
  logic [11:0] sw_out, sw_dir, sw_in_r, pad_in, pad_out_r, pad_oe_r;
  logic thermistor_used, thermistor_enable, thermistor_rc_drive;
  logic glasses_left, aux_select_one_n, aux_select_zero_n;
  logic aux_serial_out, aux_serial_clk, aux_serial_in_r;
  logic park_request_r, strap_valid_r;
  logic [1:0] lane_code_r, strap_code;
  logic [2:0] lane_count_r;
  gpio_altfunc_pin_mux #(.NUM_PINS(12)) u_gpio_altfunc_pin_mux (.mclk,
    .sys_rst, .cfg_load, .cfg_mode, .cfg_alt, .sw_out, .sw_dir, .sw_in_r,
    .thermistor_used, .thermistor_enable, .thermistor_rc_drive,
    .glasses_left, .aux_select_one_n, .aux_select_zero_n, .aux_serial_out,
    .aux_serial_clk, .aux_serial_in_r, .park_request_r, .lane_code_r,
    .lane_count_r, .strap_valid_r, .pad_in, .pad_out_r, .pad_oe_r);
  pad_far_side u_pad_far_side (.pad_out(pad_out_r), .pad_oe(pad_oe_r),
    .host_projector_on, .companion_data, .strap_code, .pad_in);
  task automatic tally_and_finish;
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic do_reset;
    sys_rst = 1'h1;
    repeat (8) @(negedge mclk);
    sys_rst = 1'h0;
  endtask
  initial begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    #20us;
    errors++;
    tally_and_finish();
  end
  initial begin
    {cfg_load, cfg_mode, cfg_alt, sw_out, sw_dir, strap_code} = '0;
    {thermistor_used, thermistor_enable, thermistor_rc_drive} = 3'h0;
    {glasses_left, aux_select_one_n, aux_select_zero_n} = 3'h0;
    {aux_serial_out, aux_serial_clk, companion_data} = 3'h0;
    host_projector_on = 1'h1;
    do_reset();
    foreach (rows[i]) begin
      {cfg_mode, cfg_alt, sw_out, sw_dir} =
        {rows[i].mode, rows[i].alt, rows[i].out, rows[i].dir};
      {thermistor_used, thermistor_enable, thermistor_rc_drive,
        glasses_left, aux_select_one_n, aux_select_zero_n,
        aux_serial_out, aux_serial_clk} = rows[i].src;
      cfg_load = 1'h1;
      @(negedge mclk);
      cfg_load = 1'h0;
      repeat (3) @(negedge mclk);
      `CHK("pad_oe", rows[i].exp_oe, pad_oe_r)
      `CHK("pad_out", rows[i].exp_out, pad_out_r & rows[i].exp_oe)
    end
    host_projector_on = 1'h0;
    companion_data = 1'h1;
    repeat (2) @(negedge mclk);
    `CHK("park_request", 1'h1, park_request_r)
    `CHK("serial_in", 1'h1, aux_serial_in_r)
    `CHK("sample_in", 2'h1, {sw_in_r[8], sw_in_r[0]})
    host_projector_on = 1'h1;
    companion_data = 1'h0;
    repeat (2) @(negedge mclk);
    `CHK("park_release", 1'h0, park_request_r)
    `CHK("serial_in_low", 1'h0, aux_serial_in_r)
    `CHK("sample_in_idle", 2'h2, {sw_in_r[8], sw_in_r[0]})
    for (int c = 0; c < 4; c++) begin
      strap_code = 2'(c);
      do_reset();
      `CHK("oe_after_reset", 12'h000, pad_oe_r)
      `CHK("strap_unlatched", 1'h0, strap_valid_r)
      repeat (4) @(negedge mclk);
      `CHK("strap_valid", 1'h1, strap_valid_r)
      `CHK("lane_code", 2'(c), lane_code_r)
      `CHK("lane_count", 3'(c + 1), lane_count_r)
      strap_code = ~strap_code;
      repeat (3) @(negedge mclk);
      `CHK("lane_hold", 2'(c), lane_code_r)
    end
    tally_and_finish();
  end
endmodule // gpio_altfunc_pin_mux_tb_top
bind gpio_altfunc_pin_mux gpio_altfunc_pin_mux_props #(.NUM_PINS(NUM_PINS))
  u_gpio_altfunc_pin_mux_props (.mclk, .sys_rst, .cfg_load, .cfg_alt,
  .pad_in, .sw_in_r, .pad_out_r, .pad_oe_r, .thermistor_used,
  .thermistor_enable, .glasses_left, .aux_serial_in_r, .park_request_r,
  .lane_code_r, .lane_count_r, .strap_valid_r);
